// ==== dv/smc_wake_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Wake sources and reset request seen by the controller
module smc_wake_model (
    // Requests from the bench
    input  wire logic                 clk,
    input  wire logic                 go,
    input  wire logic                 rst_req,
    input  wire smc_pkg::smc_wake_t   src,
    // Lines into the controller
    output var smc_pkg::smc_wake_t    wake,
    output var logic                  rst_wake
);
    import smc_pkg::*;
    int hold;

    initial begin
        wake = '0;
        rst_wake = 1'b0;
        hold = 0;
    end

    // Held well past the two-flop sync so a level wake cannot be missed
    always @(posedge clk) begin
        if (go) begin
            wake <= src;
            rst_wake <= rst_req;
            hold <= 6;
        end else if (hold > 1) begin
            hold <= hold - 1;
        end else begin
            wake <= '0;
            rst_wake <= 1'b0;
            hold <= 0;
        end
    end
endmodule : smc_wake_model

`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import smc_pkg::*;
    // ==========================================================
    // Signals
    logic CLK, RST, CTRL_WE, BROWNOUT_SLEEP_OFF_ENABLE_WE, BROWNOUT_SLEEP_OFF_WE, BROWNOUT_SLEEP_OFF_WDATA, SLEEP_EXEC;
    logic ADC_ENABLED, BROWNOUT_FUSE_EN, BROWNOUT_SLEEP_OFF, CPU_HALT, SLEEPING;
    logic WAKE_TO_ISR, ADC_START, BROWNOUT_ENABLE, EXT_RESET_WAKE, go, rst_req;
    logic [7:0]  CTRL_WDATA, CTRL_RDATA;
    logic [15:0] STARTUP_CYC;
    smc_clk_t    CLK_GATE;
    smc_wake_t   WAKE_IN, src;
    int          fail_count = 0, total_checks = 0;
    logic        brownout_sleep_off_exp = 1'b0;

    smc_sleep_ctrl u_dut (.CLK(CLK), .RST(RST), .CTRL_WE(CTRL_WE), .CTRL_WDATA(CTRL_WDATA),
        .CTRL_RDATA(CTRL_RDATA), .BROWNOUT_SLEEP_OFF_ENABLE_WE(BROWNOUT_SLEEP_OFF_ENABLE_WE), .BROWNOUT_SLEEP_OFF_WE(BROWNOUT_SLEEP_OFF_WE),
        .BROWNOUT_SLEEP_OFF_WDATA(BROWNOUT_SLEEP_OFF_WDATA), .BROWNOUT_SLEEP_OFF(BROWNOUT_SLEEP_OFF), .SLEEP_EXEC(SLEEP_EXEC),
        .CPU_HALT(CPU_HALT), .SLEEPING(SLEEPING), .WAKE_TO_ISR(WAKE_TO_ISR), .STARTUP_CYC(STARTUP_CYC),
        .BROWNOUT_FUSE_EN(BROWNOUT_FUSE_EN), .ADC_ENABLED(ADC_ENABLED), .CLK_GATE(CLK_GATE),
        .ADC_START(ADC_START), .BROWNOUT_ENABLE(BROWNOUT_ENABLE), .WAKE_IN(WAKE_IN),
        .EXT_RESET_WAKE(EXT_RESET_WAKE));

    smc_wake_model u_src (.clk(CLK), .go(go), .rst_req(rst_req), .src(src), .wake(WAKE_IN),
        .rst_wake(EXT_RESET_WAKE));

    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // ==========================================================
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run

    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : tick

    // Clock gates that each mode leaves running
    function automatic logic [6:0] gates(input int m);
        case (m)
            0: return 7'h1F;
            1: return 7'h0F;
            2: return 7'h00;
            default: return 7'h05;
        endcase
    endfunction : gates

    task automatic write_ctrl(input logic [7:0] d);
        CTRL_WE = 1'b1;
        CTRL_WDATA = d;
        tick(1);
        CTRL_WE = 1'b0;
        tick(1);
    endtask : write_ctrl

    // Delay 0 skips the enable; the write lands delay cycles after the opening edge
    task automatic set_brownout_sleep_off(input logic v, input int d);
        if (d > 0) begin
            BROWNOUT_SLEEP_OFF_ENABLE_WE = 1'b1;
            tick(1);
            BROWNOUT_SLEEP_OFF_ENABLE_WE = 1'b0;
            tick(d - 1);
        end
        BROWNOUT_SLEEP_OFF_WE = 1'b1;
        BROWNOUT_SLEEP_OFF_WDATA = v;
        tick(1);
        BROWNOUT_SLEEP_OFF_WE = 1'b0;
        tick(1);
        if (d >= 1 && d <= 4) brownout_sleep_off_exp = v;
        check({15'h0, BROWNOUT_SLEEP_OFF}, {15'h0, brownout_sleep_off_exp}, "sleep-off bit");
    endtask : set_brownout_sleep_off

    task automatic sleep_cmd(input logic [7:0] d);
        write_ctrl(d);
        SLEEP_EXEC = 1'b1;
        tick(1);
        SLEEP_EXEC = 1'b0;
    endtask : sleep_cmd

    // Pulses the partner model; its lines then stand six cycles
    task automatic fire(input smc_wake_t s, input logic r);
        src = s;
        rst_req = r;
        go = 1'b1;
        tick(1);
        go = 1'b0;
    endtask : fire

    // Fires a source and counts cycles halted after leaving sleep
    task automatic wake(input smc_wake_t s, input logic r, output int n);
        fire(s, r);
        n = 0;
        for (int i = 0; i < 3000; i++) begin
            tick(1);
            if (SLEEPING === 1'b0 && CPU_HALT === 1'b1) n++;
            if (SLEEPING === 1'b0 && CPU_HALT === 1'b0) return;
        end
        fail_count++;
        $display("[FAIL] %0t wake never completed", $time);
        complete_run();
    endtask : wake

    // ==========================================================
    // Main sequence
    initial begin
        int n, su, d, m;
        logic [7:0] b;
        logic adc;
        smc_wake_t s;
        {CTRL_WE, BROWNOUT_SLEEP_OFF_ENABLE_WE, BROWNOUT_SLEEP_OFF_WE, BROWNOUT_SLEEP_OFF_WDATA, SLEEP_EXEC, go, rst_req} = '0;
        CTRL_WDATA = 8'h00;
        STARTUP_CYC = 16'h0008;
        ADC_ENABLED = 1'b0;
        BROWNOUT_FUSE_EN = 1'b1;
        src = '0;
        RST = 1'b1;
        void'($urandom(32'hF00E));
        tick(12);
        RST = 1'b0;
        check({8'h0, CTRL_RDATA}, 16'h0000, "ctrl reset");
        check({15'h0, BROWNOUT_SLEEP_OFF}, 16'h0000, "sleep-off reset");
        check({9'h0, CLK_GATE}, 16'h007F, "gates reset");
        BROWNOUT_FUSE_EN = 1'b0;
        tick(1);
        check({15'h0, BROWNOUT_ENABLE}, 16'h0000, "fuse off");
        BROWNOUT_FUSE_EN = 1'b1;
        for (int i = 0; i < 6; i++) begin
            b = 8'($urandom);
            write_ctrl(b);
            check({8'h0, CTRL_RDATA}, {13'h0, b[2:0]}, "ctrl readback");
        end
        $display("test register done");
        set_brownout_sleep_off(1'b1, 0);
        for (int i = 0; i < 8; i++) set_brownout_sleep_off(1'($urandom), $urandom_range(6, 1));
        $display("test timed write done");
        sleep_cmd({5'h00, 2'($urandom), 1'b0});
        check({15'h0, SLEEPING}, 16'h0000, "unarmed sleep");
        check({9'h0, CLK_GATE}, 16'h007F, "unarmed gates");
        $display("test unarmed done");
        for (int i = 0; i < 8; i++) begin
            m = i % 4;
            adc = 1'($urandom);
            ADC_ENABLED = adc;
            su = $urandom_range(20, 1);
            STARTUP_CYC = 16'(su);
            set_brownout_sleep_off(1'($urandom), 1);
            sleep_cmd({5'h00, 2'(m), 1'b1});
            check({15'h0, SLEEPING}, 16'h0001, "sleeping");
            check({15'h0, CPU_HALT}, 16'h0001, "halt in sleep");
            check({9'h0, CLK_GATE}, {9'h0, gates(m)}, "gates");
            check({15'h0, ADC_START}, {15'h0, adc && m < 2}, "adc start");
            check({15'h0, BROWNOUT_ENABLE}, {15'h0, !(brownout_sleep_off_exp && m >= 2)}, "detector");
            if (m != 0) begin
                s = '0;
                s.other_io = 1'b1;
                s.ext0 = 1'b1;
                s.ext1 = 1'b1;
                s.adc_done = (m >= 2);
                s.mem_ready = (m >= 2);
                s.async_timer = (m == 2);
                fire(s, 1'b0);
                tick(10);
                check({15'h0, SLEEPING}, 16'h0001, "refused wake");
            end
            s = '0;
            if (m == 0) s.ext0 = 1'b1;
            else s.ext1_level = 1'b1;
            wake(s, 1'b0, n);
            d = (m < 2) ? 0 : (brownout_sleep_off_exp ? SMC_BOD_CYC : su);
            check(16'(n), 16'(d + SMC_HALT_CYC), "wake halt");
            check({15'h0, WAKE_TO_ISR}, 16'h0001, "isr wake");
            check({15'h0, BROWNOUT_ENABLE}, 16'h0001, "detector back");
            check({9'h0, CLK_GATE}, 16'h007F, "gates back");
        end
        $display("test modes done");
        sleep_cmd(8'h05);
        wake('0, 1'b1, n);
        check({15'h0, WAKE_TO_ISR}, 16'h0000, "reset wake");
        check(16'(n), 16'h0000, "reset wake halt");
        $display("test reset wake done");
        complete_run();
    end
endmodule : tb_top

`default_nettype wire

// ==== logic/smc_pkg.sv ====
`default_nettype none

package smc_pkg;

    // ==========================================================
    // Sleep mode encodings
    typedef enum logic [1:0] {
        SMC_MODE_IDLE = 2'h0,
        SMC_MODE_ADCNR = 2'h1,
        SMC_MODE_PDOWN = 2'h2,
        SMC_MODE_PSAVE = 2'h3
    } smc_mode_t;

    // ==========================================================
    // Sleep control register layout
    localparam int SMC_ARM_POS = 0;
    localparam int SMC_MODE_LSB = 1;
    localparam logic [7:0] SMC_CTRL_RST = 8'h00;
    localparam logic [1:0] SMC_MODE_RST = 2'h0;
    localparam logic SMC_BROWNOUT_SLEEP_OFF_RST = 1'b0;

    // ==========================================================
    // Timing
    localparam int SMC_CLK_HZ = 10_000_000;
    localparam int SMC_HALT_CYC = 4;
    localparam int SMC_BOD_US = 60;
    localparam int SMC_BOD_CYC = SMC_BOD_US * (SMC_CLK_HZ / 1_000_000);
    localparam int SMC_TIMED_CYC = 4;
    localparam int SMC_CNT_W = 16;

    // ==========================================================
    // Clock domain gates, one bit each, high means running
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic async;
        logic main_osc;
        logic timer_osc;
    } smc_clk_t;

    // Wake sources
    typedef struct packed {
        logic ext0;
        logic ext1;
        logic ext0_level;
        logic ext1_level;
        logic pin_change;
        logic mem_ready;
        logic adc_done;
        logic watchdog;
        logic start_cond;
        logic async_timer;
        logic other_io;
    } smc_wake_t;

endpackage : smc_pkg

`default_nettype wire

// ==== logic/smc_sleep_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Arm bit plus sleep instruction enters sleep
// - Code 00 idle stops cpu and flash
// - Code 01 also stops io clock
// - Code 10 power-down halts all generated clocks
// - Power-down stops oscillator, async wakes stay
// - Wake holds cpu start-up plus four cycles
// - Register file and SRAM never cleared here
// - Reset during sleep restarts at reset vector
// - Idle wakes on any enabled interrupt
// - Noise reduction wakes on listed sources only
// - Power-down wakes on listed sources only
// - Deep modes wake external lines on level only
// - Idle or noise entry starts ADC conversion
// - Power-down wake waits fuse start-up period
// - Sleep-off bit kills detector in deep modes
// - Detector off on entry, back on wake
// - Detector-off wake extends to sixty microseconds
// - Sleep-off bit written only via timed sequence
// - Code 11 power-save keeps async and timer osc
// - Control register mode bits 2:1, arm bit 0
module smc_sleep_ctrl (
    // Clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RST,
    // Sleep control register write from core
    input  wire logic                   CTRL_WE,
    input  wire logic [7:0]             CTRL_WDATA,
    output logic      [7:0]             CTRL_RDATA,
    // Sleep-off bit timed write
    input  wire logic                   BROWNOUT_SLEEP_OFF_ENABLE_WE,
    input  wire logic                   BROWNOUT_SLEEP_OFF_WE,
    input  wire logic                   BROWNOUT_SLEEP_OFF_WDATA,
    output logic                        BROWNOUT_SLEEP_OFF,
    // Core handshake
    input  wire logic                   SLEEP_EXEC,
    output logic                        CPU_HALT,
    output logic                        SLEEPING,
    output logic                        WAKE_TO_ISR,
    // Clock system
    input  wire logic [smc_pkg::SMC_CNT_W-1:0] STARTUP_CYC,
    input  wire logic                   BROWNOUT_FUSE_EN,
    input  wire logic                   ADC_ENABLED,
    output var smc_pkg::smc_clk_t       CLK_GATE,
    output logic                        ADC_START,
    output logic                        BROWNOUT_ENABLE,
    // Wake sources, from pins or async logic
    input  wire smc_pkg::smc_wake_t     WAKE_IN,
    input  wire logic                   EXT_RESET_WAKE
);
    import smc_pkg::*;

    // ==========================================================
    // Synchronise wake inputs; they come from stopped domains
    smc_wake_t wake_s1;
    smc_wake_t wake_s2;
    logic      rst_s1;
    logic      rst_s2;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wake_s1 <= '0;
            wake_s2 <= '0;
            rst_s1  <= 1'b0;
            rst_s2  <= 1'b0;
        end else begin
            wake_s1 <= WAKE_IN;
            wake_s2 <= wake_s1;
            rst_s1  <= EXT_RESET_WAKE;
            rst_s2  <= rst_s1;
        end
    end

    // ==========================================================
    // Wake filter per mode
    function automatic logic wake_ok(input smc_mode_t m, input smc_wake_t w);
        logic lv;
        lv = w.ext0_level | w.ext1_level | w.pin_change | w.watchdog | w.start_cond;
        case (m)
            SMC_MODE_IDLE:  wake_ok = |w;
            SMC_MODE_ADCNR: wake_ok = lv | w.adc_done | w.async_timer | w.mem_ready;
            SMC_MODE_PDOWN: wake_ok = lv;
            default:        wake_ok = lv | w.async_timer;
        endcase
    endfunction : wake_ok

    // ==========================================================
    // Control register and timed sleep-off write
    logic                 arm;
    smc_mode_t            mode;
    logic                 brownout_sleep_off;
    logic [2:0]           tmo;
    logic                 next_arm;
    smc_mode_t            next_mode;
    logic                 next_brownout_sleep_off;
    logic [2:0]           next_tmo;

    always_comb begin
        next_arm  = arm;
        next_mode = mode;
        next_brownout_sleep_off = brownout_sleep_off;
        next_tmo  = (tmo != 3'h0) ? tmo - 3'h1 : 3'h0;
        if (CTRL_WE) begin
            next_arm  = CTRL_WDATA[SMC_ARM_POS];
            next_mode = smc_mode_t'(CTRL_WDATA[SMC_MODE_LSB +: 2]);
        end
        if (BROWNOUT_SLEEP_OFF_WE && tmo != 3'h0) begin
            next_brownout_sleep_off = BROWNOUT_SLEEP_OFF_WDATA;
            next_tmo  = 3'h0;
        end else if (BROWNOUT_SLEEP_OFF_ENABLE_WE && tmo == 3'h0) begin
            next_tmo  = 3'(SMC_TIMED_CYC);
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            arm  <= 1'b0;
            mode <= SMC_MODE_IDLE;
            brownout_sleep_off <= SMC_BROWNOUT_SLEEP_OFF_RST;
            tmo  <= 3'h0;
        end else begin
            arm  <= next_arm;
            mode <= next_mode;
            brownout_sleep_off <= next_brownout_sleep_off;
            tmo  <= next_tmo;
        end
    end

    assign CTRL_RDATA         = {5'h00, mode, arm};
    assign BROWNOUT_SLEEP_OFF = brownout_sleep_off;

    // ==========================================================
    // Sleep sequencer
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_START, ST_HALT} smc_state_t;
    smc_state_t           state;
    smc_state_t           next_state;
    logic [SMC_CNT_W-1:0] cnt;
    logic [SMC_CNT_W-1:0] next_cnt;
    logic                 bod_off;
    logic                 next_bod_off;
    logic                 adc_go;
    logic                 next_adc_go;
    logic                 isr;
    logic                 next_isr;
    logic                 deep;
    logic [SMC_CNT_W-1:0] wait_cyc;

    assign deep = (mode == SMC_MODE_PDOWN) || (mode == SMC_MODE_PSAVE);

    always_comb begin
        next_state   = state;
        next_cnt     = (cnt != '0) ? cnt - 1'b1 : cnt;
        next_bod_off = bod_off;
        next_adc_go  = 1'b0;
        next_isr     = isr;
        wait_cyc     = '0;
        case (state)
            ST_RUN: begin
                // Unarmed sleep falls through as a no-op
                if (SLEEP_EXEC && arm) begin
                    next_state   = ST_SLEEP;
                    next_bod_off = brownout_sleep_off && deep;
                    next_adc_go  = ADC_ENABLED && !deep;
                    next_isr     = 1'b0;
                end
            end
            ST_SLEEP: begin
                if (rst_s2) begin
                    next_state   = ST_RUN;
                    next_bod_off = 1'b0;
                    next_isr     = 1'b0;
                end else if (wake_ok(mode, wake_s2)) begin
                    next_isr     = 1'b1;
                    next_bod_off = 1'b0;
                    // Start-up only after stopped oscillator; detector needs its settle time
                    wait_cyc = deep ? STARTUP_CYC : '0;
                    if (bod_off && wait_cyc < SMC_CNT_W'(SMC_BOD_CYC)) begin
                        wait_cyc = SMC_CNT_W'(SMC_BOD_CYC);
                    end
                    // No start-up wait goes straight to the four halt cycles
                    if (wait_cyc == '0) begin
                        next_state = ST_HALT;
                        next_cnt   = SMC_CNT_W'(SMC_HALT_CYC - 1);
                    end else begin
                        next_state = ST_START;
                        next_cnt   = wait_cyc - 1'b1;
                    end
                end
            end
            ST_START: begin
                if (cnt == '0) begin
                    next_state = ST_HALT;
                    next_cnt   = SMC_CNT_W'(SMC_HALT_CYC - 1);
                end
            end
            default: begin
                if (cnt == '0) begin
                    next_state = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state   <= ST_RUN;
            cnt     <= '0;
            bod_off <= 1'b0;
            adc_go  <= 1'b0;
            isr     <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            bod_off <= next_bod_off;
            adc_go  <= next_adc_go;
            isr     <= next_isr;
        end
    end

    // ==========================================================
    // Clock gating; memories keep their contents since only clocks stop
    always_comb begin
        CLK_GATE = '1;
        if (state == ST_SLEEP) begin
            CLK_GATE.cpu   = 1'b0;
            CLK_GATE.flash = 1'b0;
            case (mode)
                SMC_MODE_IDLE: ;
                SMC_MODE_ADCNR: CLK_GATE.io = 1'b0;
                SMC_MODE_PDOWN: begin
                    CLK_GATE = '0;
                end
                default: begin
                    CLK_GATE           = '0;
                    CLK_GATE.async     = 1'b1;
                    CLK_GATE.timer_osc = 1'b1;
                end
            endcase
        end else if (state != ST_RUN) begin
            CLK_GATE.cpu   = 1'b0;
            CLK_GATE.flash = 1'b0;
        end
    end

    assign CPU_HALT        = (state != ST_RUN);
    assign SLEEPING        = (state == ST_SLEEP);
    assign WAKE_TO_ISR     = isr;
    assign ADC_START       = adc_go;
    assign BROWNOUT_ENABLE = BROWNOUT_FUSE_EN && !bod_off;

    // ==========================================================
    // Checks
    a_unarmed_noop: assert property (@(posedge CLK) disable iff (RST)
        (state == ST_RUN && SLEEP_EXEC && !arm) |=> state == ST_RUN)
        else $error("unarmed sleep entered sleep");
    a_armed_entry: assert property (@(posedge CLK) disable iff (RST)
        (state == ST_RUN && SLEEP_EXEC && arm) |=> SLEEPING)
        else $error("armed sleep not entered");
    a_idle_gate: assert property (@(posedge CLK) disable iff (RST)
        (SLEEPING && mode == SMC_MODE_IDLE) |-> (!CLK_GATE.cpu && CLK_GATE.io && CLK_GATE.adc))
        else $error("idle gating wrong");
    a_adcnr_gate: assert property (@(posedge CLK) disable iff (RST)
        (SLEEPING && mode == SMC_MODE_ADCNR) |-> (!CLK_GATE.io && CLK_GATE.adc))
        else $error("noise reduction gating wrong");
    a_pdown_gate: assert property (@(posedge CLK) disable iff (RST)
        (SLEEPING && mode == SMC_MODE_PDOWN) |-> CLK_GATE == '0)
        else $error("power-down clock running");
    a_psave_gate: assert property (@(posedge CLK) disable iff (RST)
        (SLEEPING && mode == SMC_MODE_PSAVE) |-> (CLK_GATE.async && !CLK_GATE.main_osc))
        else $error("power-save gating wrong");
    a_halt_four: assert property (@(posedge CLK) disable iff (RST)
        (state != ST_HALT) ##1 (state == ST_HALT) |-> CPU_HALT [*4] ##1 !CPU_HALT)
        else $error("halt not four cycles");
    a_reset_wake: assert property (@(posedge CLK) disable iff (RST)
        (SLEEPING && rst_s2) |=> (!CPU_HALT && !WAKE_TO_ISR))
        else $error("reset wake wrong");
    a_bod_off: assert property (@(posedge CLK) disable iff (RST)
        (state == ST_RUN && SLEEP_EXEC && arm && brownout_sleep_off && deep) |=> !BROWNOUT_ENABLE)
        else $error("detector not off");
    a_bod_idle: assert property (@(posedge CLK) disable iff (RST)
        (SLEEPING && !deep && BROWNOUT_FUSE_EN) |-> BROWNOUT_ENABLE)
        else $error("detector off in light mode");
    a_brownout_sleep_off_locked: assert property (@(posedge CLK) disable iff (RST)
        (tmo == 3'h0) |=> brownout_sleep_off == $past(brownout_sleep_off))
        else $error("sleep-off written outside sequence");
    a_adc_start: assert property (@(posedge CLK) disable iff (RST)
        (state == ST_RUN && SLEEP_EXEC && arm && ADC_ENABLED && !deep) |=> ADC_START)
        else $error("adc not started");
    a_pdown_filter: assert property (@(posedge CLK) disable iff (RST)
        (SLEEPING && mode == SMC_MODE_PDOWN && !rst_s2
         && !(wake_s2.ext0_level || wake_s2.ext1_level || wake_s2.pin_change
              || wake_s2.watchdog || wake_s2.start_cond)) |=> SLEEPING)
        else $error("edge wake in power-down");

    c_idle_wake: cover property (@(posedge CLK) disable iff (RST)
        SLEEPING && mode == SMC_MODE_IDLE ##1 state == ST_HALT);
    c_pdown_wake: cover property (@(posedge CLK) disable iff (RST)
        SLEEPING && mode == SMC_MODE_PDOWN ##1 state == ST_START);
    c_bod_wake: cover property (@(posedge CLK) disable iff (RST)
        bod_off && SLEEPING ##1 state == ST_START);
    c_reset_wake: cover property (@(posedge CLK) disable iff (RST)
        SLEEPING && rst_s2);

endmodule : smc_sleep_ctrl

`default_nettype wire
